//--- core/api_params.svh
`ifndef API_PARAMS_SVH
`define API_PARAMS_SVH
// Ancillary data flag and timing reference words.
`define API_ADF0 10'h000
`define API_ADF1 10'h3FF
// Identifier of an end-marker packet, low eight bits.
`define API_END_DID 8'h88
// Word positions inside a packet, counted from the first flag word.
`define API_POS_DID 9'h003
`define API_POS_DBN 9'h004
`define API_POS_DC 9'h005
`define API_POS_UDW 9'h006
// Flag, header and checksum words that come on top of the user words.
`define API_PKT_OVH 12'h007
// Bits of the XYZ word.
`define API_XYZ_V 7
`define API_XYZ_H 6
// Default sizes of the horizontal and vertical ancillary spaces in words.
`define API_HANC_LEN 12'h10C
`define API_VANC_LEN 12'h5A0
// Register byte offsets.
`define API_OFF_CTRL 4'h0
`define API_OFF_STAT 4'h4
`define API_OFF_CNT 4'h8
// Reset value of the insertion enable.
`define API_CTRL_RST 1'b1
// Bus responses.
`define API_RESP_OK 2'h0
`define API_RESP_ERR 2'h2
`endif

//--- core/api_pkg.sv
`default_nettype none
package api_pkg;
   typedef enum logic [2:0] {
      ST_WAIT = 3'b000,
      ST_POINT = 3'b001,
      ST_SEND = 3'b010,
      ST_HDR = 3'b011,
      ST_BODY = 3'b100
   } api_state_t;
   typedef struct packed {
      api_state_t st;
      logic [8:0] idx;
      logic [8:0] skip;
      logic [11:0] pos;
      logic [9:0] h1;
      logic [9:0] h2;
      logic [9:0] h3;
      logic sp_h;
      logic sp_v;
      logic adf_ok;
      logic [8:0] cs;
      logic pending;
      logic [7:0] did;
      logic [7:0] dbn;
      logic [7:0] dc;
      logic sel_h;
      logic sel_v;
      logic enable;
      logic [15:0] ins_cnt;
      logic [15:0] abt_cnt;
      logic aw_full;
      logic [3:0] aw_addr;
      logic w_full;
      logic w_bit0;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } api_regs_t;
endpackage
`default_nettype wire

//--- core/api_packet_inserter.sv
`timescale 1ns/1ns
`default_nettype none
`include "api_params.svh"
// Notes on behaviour
// - Find EAV/SAV; SAV opens space only in blanking.
// - Insert after symbol only if space free.
// - Ready after free space began: wait.
// - Overwrite an end-marker packet.
// - Skip existing packets using their count word.
// - Insert only when remaining space fits packet.
// - Start sending while insertion may still succeed.
// - Cancel on non-end-marker packet at point.
// - Cancel when switching flag follows send.
// - Cancelled packet is kept and resent.
// - End-marker decided from identifier word.
// - Video path and timing add no latency.
// - One strobe loads block number or secondary id.
// - Header and user writes in any order.
// - Parity option sets bits eight and nine.
// - Both selections: first space with room.
// - Selections registered on ready, used by inserter.
// - User store 256 words of 10 bits.
// - One pending packet, one per space.
// - Downstream stage lands after upstream packet.
module api_packet_inserter #(
   parameter int UDW_DEPTH = 256,
   parameter int UDW_AW = 8,
   parameter logic [11:0] HANC_LEN = `API_HANC_LEN,
   parameter logic [11:0] VANC_LEN = `API_VANC_LEN
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite register port.
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Video stream and timing.
   input wire logic [9:0] vid_in,
   input wire logic sw_int,
   input wire logic field_in,
   input wire logic v_blank_in,
   input wire logic h_blank_in,
   output logic [9:0] vid_out,
   output logic field_out,
   output logic v_blank_out,
   output logic h_blank_out,
   // Raw packet loading.
   input wire logic [9:0] data_in,
   input wire logic [UDW_AW-1:0] udw_addr,
   input wire logic load_identifier,
   input wire logic load_block_or_secondary,
   input wire logic load_word_count,
   input wire logic load_user_word,
   input wire logic calc_udw_parity,
   input wire logic pkt_rdy,
   input wire logic hanc_sel,
   input wire logic vanc_sel,
   output logic pkt_in_empty,
   // Generator handshake.
   output logic send_pkt,
   output logic abort_pkt
);
   api_pkg::api_regs_t r;
   api_pkg::api_regs_t n;
   logic [9:0] ram [UDW_DEPTH];
   logic [9:0] gen_word;
   logic [8:0] last_idx;
   logic [11:0] rem;
   logic fits;
   logic trs_xyz;
   logic can_send;
   logic wr_go;

   // Adds even parity in bit 8 and its complement in bit 9.
   function automatic logic [9:0] par10(input logic [7:0] v);
      return {~(^v), ^v, v};
   endfunction

   // Timing signals pass straight through.
   // zero latency path
   assign field_out = field_in;
   assign v_blank_out = v_blank_in;
   assign h_blank_out = h_blank_in;

   // Bus handshakes and register outputs.
   assign s_axi_awready = ~r.aw_full;
   assign s_axi_wready = ~r.w_full;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = ~r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign wr_go = r.aw_full & r.w_full & ~r.bvalid;
   assign pkt_in_empty = ~r.pending;

   // Packet word at the current send index, checksum last.
   // shared block or secondary word
   always_comb begin
      last_idx = {1'b0, r.dc} + `API_POS_UDW;
      if (r.idx == 9'h000) begin
         gen_word = `API_ADF0;
      end else if (r.idx < `API_POS_DID) begin
         gen_word = `API_ADF1;
      end else if (r.idx == `API_POS_DID) begin
         gen_word = par10(r.did);
      end else if (r.idx == `API_POS_DBN) begin
         gen_word = par10(r.dbn);
      end else if (r.idx == `API_POS_DC) begin
         gen_word = par10(r.dc);
      end else if (r.idx < last_idx) begin
         gen_word = ram[UDW_AW'(r.idx - `API_POS_UDW)];
      end else begin
         gen_word = {~r.cs[8], r.cs};
      end
   end

   // Space bookkeeping: TRS detection and room left in the space.
   // timing symbol scan
   assign trs_xyz = (r.h3 == `API_ADF1) && (r.h2 == `API_ADF0) && (r.h1 == `API_ADF0);
   assign rem = (r.sp_h ? HANC_LEN : VANC_LEN) - r.pos;
   assign fits = ({4'h0, r.dc} + `API_PKT_OVH) <= rem;
   assign can_send = r.pending & r.enable & ((r.sp_h & r.sel_h) | (r.sp_v & r.sel_v)) & fits;

   // User word store, written only while the store is empty.
   // single user word writes
   always_ff @(posedge aclk) begin
      if (load_user_word && !r.pending) begin
         ram[udw_addr] <= calc_udw_parity ? par10(data_in[7:0]) : data_in;
      end
   end

   // Next-state logic for the bus, the store and the inserter.
   always_comb begin
      n = r;
      vid_out = vid_in;
      send_pkt = 1'b0;
      abort_pkt = 1'b0;
      n.h1 = vid_in;
      n.h2 = r.h1;
      n.h3 = r.h2;
      if (r.pos != 12'hFFF) begin
         n.pos = r.pos + 12'h001;
      end
      // Write channel: address and data latched in either order.
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s_axi_awvalid && !r.aw_full) begin
         n.aw_full = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_full) begin
         n.w_full = 1'b1;
         n.w_bit0 = s_axi_wdata[0];
         n.w_strb0 = s_axi_wstrb[0];
      end
      if (wr_go) begin
         n.aw_full = 1'b0;
         n.w_full = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `API_RESP_OK;
         if (r.aw_addr == `API_OFF_CTRL) begin
            if (r.w_strb0) begin
               n.enable = r.w_bit0;
            end
         end else if (r.aw_addr == `API_OFF_CNT) begin
            n.ins_cnt = 16'h0000;
            n.abt_cnt = 16'h0000;
         end else if (r.aw_addr != `API_OFF_STAT) begin
            n.bresp = `API_RESP_ERR;
         end
      end
      // Read channel.
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !r.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp = `API_RESP_OK;
         if (s_axi_araddr == `API_OFF_CTRL) begin
            n.rdata = {31'h00000000, r.enable};
         end else if (s_axi_araddr == `API_OFF_STAT) begin
            n.rdata = {29'h00000000, r.st == api_pkg::ST_SEND, r.pending, ~r.pending};
         end else if (s_axi_araddr == `API_OFF_CNT) begin
            n.rdata = {r.abt_cnt, r.ins_cnt};
         end else begin
            n.rdata = 32'h00000000;
            n.rresp = `API_RESP_ERR;
         end
      end
      // Loading is open only while the store is empty.
      // any write order
      if (!r.pending) begin
         if (load_identifier) begin
            n.did = data_in[7:0];
         end
         if (load_block_or_secondary) begin
            n.dbn = data_in[7:0];
         end
         if (load_word_count) begin
            n.dc = data_in[7:0];
         end
         if (pkt_rdy) begin
            n.pending = 1'b1;
            n.sel_h = hanc_sel;
            n.sel_v = vanc_sel;
         end
      end
      // Inserter state machine.
      case (r.st)
         api_pkg::ST_POINT: begin
            n.idx = 9'h001;
            if (can_send) begin
               send_pkt = 1'b1;
               vid_out = gen_word;
               n.st = api_pkg::ST_SEND;
               n.adf_ok = (vid_in == `API_ADF0);
               n.cs = 9'h000;
            end else if (vid_in == `API_ADF0) begin
               n.st = api_pkg::ST_HDR;
            end else begin
               n.st = api_pkg::ST_WAIT;
            end
         end
         api_pkg::ST_SEND: begin
            vid_out = gen_word;
            n.idx = r.idx + 9'h001;
            if (r.idx >= `API_POS_DID) begin
               n.cs = r.cs + gen_word[8:0];
            end
            if (r.idx < `API_POS_DID) begin
               n.adf_ok = r.adf_ok & (vid_in == `API_ADF1);
            end
            if (r.idx == 9'h001 && sw_int) begin
               abort_pkt = 1'b1;
               vid_out = vid_in;
               n.st = api_pkg::ST_WAIT;
               n.abt_cnt = r.abt_cnt + 16'h0001;
            end else if (r.idx == `API_POS_DID && r.adf_ok && vid_in[7:0] != `API_END_DID) begin
               abort_pkt = 1'b1;
               vid_out = vid_in;
               n.st = api_pkg::ST_HDR;
               n.abt_cnt = r.abt_cnt + 16'h0001;
            end else if (r.idx == last_idx) begin
               n.pending = 1'b0;
               n.st = api_pkg::ST_WAIT;
               n.ins_cnt = r.ins_cnt + 16'h0001;
            end
         end
         api_pkg::ST_HDR: begin
            n.idx = r.idx + 9'h001;
            if (r.idx < `API_POS_DID && vid_in != `API_ADF1) begin
               n.st = api_pkg::ST_WAIT;
            end else if (r.idx == `API_POS_DC) begin
               n.skip = {1'b0, vid_in[7:0]};
               n.st = api_pkg::ST_BODY;
            end
         end
         api_pkg::ST_BODY: begin
            n.skip = r.skip - 9'h001;
            if (r.skip == 9'h000) begin
               n.st = api_pkg::ST_POINT;
               n.idx = 9'h000;
            end
         end
         default: begin
            n.st = api_pkg::ST_WAIT;
         end
      endcase
      // A timing symbol outside a send opens a new space on the next word; SAV in active video opens none.
      // space type from XYZ
      if (trs_xyz && r.st != api_pkg::ST_SEND) begin
         n.pos = 12'h000;
         n.idx = 9'h000;
         n.sp_h = vid_in[`API_XYZ_H];
         n.sp_v = ~vid_in[`API_XYZ_H] & vid_in[`API_XYZ_V];
         n.st = (vid_in[`API_XYZ_H] | vid_in[`API_XYZ_V]) ? api_pkg::ST_POINT : api_pkg::ST_WAIT;
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.enable <= `API_CTRL_RST;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_send_point: assert property (send_pkt |-> r.st == api_pkg::ST_POINT && r.pending && r.enable)
      else $error("send request outside an insertion point");
   a_send_room: assert property (send_pkt |-> ({4'h0, r.dc} + `API_PKT_OVH) <= rem)
      else $error("send request without room");
   a_sw_abort: assert property (send_pkt ##1 sw_int |-> abort_pkt ##1 r.st == api_pkg::ST_WAIT && r.pending)
      else $error("switching interval did not cancel");
   a_foreign_abort: assert property (r.st == api_pkg::ST_SEND && r.idx == `API_POS_DID && r.adf_ok
      && vid_in[7:0] != `API_END_DID && !abort_pkt |-> 1'b0)
      else $error("foreign packet not cancelled");
   a_end_keep: assert property (r.st == api_pkg::ST_SEND && r.idx == `API_POS_DID && r.adf_ok
      && vid_in[7:0] == `API_END_DID |-> !abort_pkt && vid_out == par10(r.did))
      else $error("end marker not overwritten");
   a_pass_through: assert property (r.st != api_pkg::ST_SEND && !send_pkt |-> vid_out == vid_in
      && field_out == field_in && h_blank_out == h_blank_in)
      else $error("video altered outside a send");
   a_sel_capture: assert property (pkt_rdy && !r.pending |=> r.pending && r.sel_h == $past(hanc_sel)
      && r.sel_v == $past(vanc_sel))
      else $error("space selection not captured");
   a_empty_again: assert property (r.st == api_pkg::ST_SEND && r.idx == last_idx && !abort_pkt |=> pkt_in_empty
      && r.ins_cnt == $past(r.ins_cnt) + 16'h0001)
      else $error("store not emptied after send");
   a_late_ready: assert property (r.st == api_pkg::ST_WAIT && !trs_xyz |=> !send_pkt)
      else $error("insertion into space already begun");
   a_udw_parity: assert property (load_user_word && calc_udw_parity && !r.pending |=>
      ram[$past(udw_addr)][8] == ^($past(data_in) & 10'h0FF) && ram[$past(udw_addr)][9] != ram[$past(udw_addr)][8])
      else $error("user word parity wrong");
endmodule
`default_nettype wire

//--- sim/api_writer.sv
`timescale 1ns/1ns
`default_nettype none
// Writer on the far side of the packet store; loads raw words on request.
module api_writer (
   // Clock and store status.
   input wire logic aclk,
   input wire logic pkt_in_empty,
   // Raw packet loading.
   output logic [9:0] data_in,
   output logic [7:0] udw_addr,
   output logic load_identifier,
   output logic load_block_or_secondary,
   output logic load_word_count,
   output logic load_user_word,
   output logic calc_udw_parity,
   output logic pkt_rdy,
   output logic hanc_sel,
   output logic vanc_sel
);
   // Everything idle at time zero.
   initial begin
      data_in = 10'h000;
      udw_addr = 8'h00;
      {load_user_word, load_word_count, load_block_or_secondary, load_identifier} = 4'h0;
      {calc_udw_parity, pkt_rdy, hanc_sel, vanc_sel} = 4'h0;
   end

   // One load; k selects the strobe, header bytes sit in the low eight bits.
   task put(input logic [3:0] k, input logic p, input logic [9:0] d, input logic [7:0] a);
      do @(negedge aclk); while (pkt_in_empty !== 1'b1);
      @(posedge aclk);
      {load_user_word, load_word_count, load_block_or_secondary, load_identifier} <= k;
      calc_udw_parity <= p;
      data_in <= d;
      udw_addr <= a;
      @(posedge aclk);
      {load_user_word, load_word_count, load_block_or_secondary, load_identifier} <= 4'h0;
      calc_udw_parity <= 1'b0;
      data_in <= ~d;
   endtask

   // one-cycle ready with selections; a single stage needs no ready arbitration.
   task ready(input logic hs, input logic vs);
      @(posedge aclk);
      pkt_rdy <= 1'b1;
      hanc_sel <= hs;
      vanc_sel <= vs;
      @(posedge aclk);
      {pkt_rdy, hanc_sel, vanc_sel} <= 3'h0;
   endtask
endmodule
`default_nettype wire

//--- sim/api_packet_inserter_test.sv
`timescale 1ns/1ns
`default_nettype none
module api_packet_inserter_test;
   logic aclk, aresetn, awv, awr, wv, wr, bv, bq, arv, arr, rv, rq, sw_int, fi, vi, hi, fo, vo, ho;
   logic [3:0] awa, ara, wst;
   logic [31:0] wd, rdt;
   logic [1:0] br, rr;
   logic [9:0] vid_in, vid_out, din;
   logic [7:0] ua;
   logic l_id, l_bk, l_wc, l_uw, cp, pr, hs, vs, empty, send, abrt;
   logic [9:0] pkt[9];
   logic [8:0] s;
   int fails = 0;
   int tests_run = 0;

   api_packet_inserter #(.HANC_LEN(12'h010), .VANC_LEN(12'h014)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rq), .vid_in(vid_in), .sw_int(sw_int), .field_in(fi), .v_blank_in(vi),
      .h_blank_in(hi), .vid_out(vid_out), .field_out(fo), .v_blank_out(vo), .h_blank_out(ho), .data_in(din),
      .udw_addr(ua), .load_identifier(l_id), .load_block_or_secondary(l_bk), .load_word_count(l_wc),
      .load_user_word(l_uw), .calc_udw_parity(cp), .pkt_rdy(pr), .hanc_sel(hs), .vanc_sel(vs),
      .pkt_in_empty(empty), .send_pkt(send), .abort_pkt(abrt));
   api_writer u_wr (.aclk(aclk), .pkt_in_empty(empty), .data_in(din), .udw_addr(ua), .load_identifier(l_id),
      .load_block_or_secondary(l_bk), .load_word_count(l_wc), .load_user_word(l_uw), .calc_udw_parity(cp),
      .pkt_rdy(pr), .hanc_sel(hs), .vanc_sel(vs));

   // Free-running 20 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Hang guard.
   initial begin
      repeat (5000) @(posedge aclk);
      fails++;
      wrap_up;
   end

   function automatic logic [9:0] par(input logic [7:0] b);
      return {~(^b), ^b, b};
   endfunction

   task wrap_up;
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // One bus transfer; a read compares against d.
   task axi(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tr;
      logic [31:0] rd;
      logic [1:0] rs;
      tr = 1'b0;
      @(posedge aclk);
      if (w) begin
         awa <= a;
         wd <= d;
         awv <= 1'b1;
         wv <= 1'b1;
         bq <= 1'b1;
      end else begin
         ara <= a;
         arv <= 1'b1;
         rq <= 1'b1;
      end
      while (!tr) begin
         @(negedge aclk);
         ta = w ? (awv && awr) : (arv && arr);
         tw = wv && wr;
         tr = w ? bv : rv;
         rs = w ? br : rr;
         rd = rdt;
         @(posedge aclk);
         if (ta && w) awv <= 1'b0;
         if (ta && !w) arv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      bq <= 1'b0;
      rq <= 1'b0;
      chk(rs, er);
      if (!w) chk(rd, d);
   endtask

   // Loads the packet in scrambled order, then marks it ready.
   task load(input logic h, input logic v);
      u_wr.put(4'h8, 1'b0, 10'h2AA, 8'h01);
      u_wr.put(4'h4, 1'b0, 10'h002, 8'h00);
      u_wr.put(4'h8, 1'b1, 10'h055, 8'h00);
      u_wr.put(4'h1, 1'b0, 10'h041, 8'h00);
      u_wr.put(4'h2, 1'b0, 10'h007, 8'h00);
      u_wr.ready(h, v);
      @(negedge aclk);
      chk(empty, 1'b0);
   endtask

   // One space: timing symbol, optional existing packet (edc<0: none), filler.
   task space(input logic [9:0] xyz, input logic sw, input logic [7:0] edid, input int edc, input int off,
              input int ln, input int ab);
      logic [9:0] w[$];
      logic [9:0] e;
      w = {10'h3FF, 10'h000, 10'h000, xyz};
      if (edc >= 0) begin
         w = {w, 10'h000, 10'h3FF, 10'h3FF, par(edid), par(8'h01), par(edc[7:0])};
         repeat (edc) w.push_back(10'h1C0);
         w.push_back(10'h155);
      end
      while (w.size() < 24) w.push_back(10'h040);
      for (int i = 0; i < 24; i++) begin
         @(posedge aclk);
         vid_in <= w[i];
         sw_int <= sw && i > 3;
         {fi, vi, hi} <= w[i][2:0];
         #1;
         e = (i - 4 >= off && i - 4 < off + ln) ? pkt[i-4-off] : w[i];
         chk(vid_out, e);
         chk({fo, vo, ho}, w[i][2:0]);
         if (i > 3) chk(abrt, i - 4 == ab);
         // A send starts at the insertion offset, or at the point of a try cut at the identifier.
         if (i > 3) chk(send, (ln > 0 && i - 4 == off) || (ab == 3 && i == 4));
      end
   endtask

   // Main sequence.
   initial begin
      {awv, wv, bq, arv, rq, sw_int, fi, vi, hi} = 9'h000;
      {awa, ara, wst, wd} = {4'h0, 4'h0, 4'hF, 32'h0};
      vid_in = 10'h040;
      aresetn = 1'b0;
      pkt = '{10'h000, 10'h3FF, 10'h3FF, par(8'h41), par(8'h07), par(8'h02), par(8'h55), 10'h2AA, 10'h000};
      s = 9'h000;
      for (int i = 3; i < 8; i++) s = s + pkt[i][8:0];
      pkt[8] = {~s[8], s};
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(empty, 1'b1);
      axi(1'b0, 4'h0, 32'h1, 2'h0);
      load(1'b0, 1'b1);
      space(10'h240, 1'b0, 8'h00, -1, -1, 0, -1);
      space(10'h200, 1'b0, 8'h00, -1, -1, 0, -1);
      space(10'h380, 1'b0, 8'h41, 1, 8, 9, 3);
      chk(empty, 1'b1);
      load(1'b1, 1'b1);
      space(10'h240, 1'b0, 8'h88, 3, 0, 9, -1);
      load(1'b1, 1'b0);
      space(10'h240, 1'b1, 8'h00, -1, 0, 1, 1);
      space(10'h240, 1'b0, 8'h41, 4, -1, 0, 3);
      space(10'h240, 1'b0, 8'h00, -1, 0, 9, -1);
      axi(1'b0, 4'h8, 32'h00030003, 2'h0);
      axi(1'b1, 4'h8, 32'h0, 2'h0);
      axi(1'b0, 4'h8, 32'h0, 2'h0);
      // With byte lane 0 off the enable must keep its value.
      wst <= 4'hE;
      axi(1'b1, 4'h0, 32'h0, 2'h0);
      axi(1'b0, 4'h0, 32'h1, 2'h0);
      wst <= 4'hF;
      axi(1'b1, 4'h0, 32'h0, 2'h0);
      load(1'b1, 1'b0);
      axi(1'b0, 4'h4, 32'h2, 2'h0);
      space(10'h240, 1'b0, 8'h00, -1, -1, 0, -1);
      axi(1'b0, 4'hC, 32'h0, 2'h2);
      axi(1'b1, 4'hC, 32'h5, 2'h2);
      axi(1'b1, 4'h0, 32'h1, 2'h0);
      space(10'h240, 1'b0, 8'h00, -1, 0, 9, -1);
      axi(1'b0, 4'h4, 32'h1, 2'h0);
      // Ready comes after the point of a free space, so that space stays untouched.
      fork
         space(10'h240, 1'b0, 8'h00, -1, -1, 0, -1);
         load(1'b1, 1'b0);
      join
      space(10'h240, 1'b0, 8'h00, -1, 0, 9, -1);
      wrap_up;
   end
endmodule
`default_nettype wire
